// ---- lles_regs.sv ----
// link error status, debug zone, profiling and radio control registers
`timescale 1ns/100ps
`include "lles_cfg.svh"
module lles_regs (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire lles_pkg::lles_word_t wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire lles_pkg::lles_word_t wb_dat_i,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    output lles_pkg::lles_word_t   wb_dat_o,
    input  wire logic [15:0]       reg_access_addr_i,
    input  wire logic [15:0]       mem_access_addr_i,
    output logic                   register_zone_hit_o,
    output logic                   exchange_mem_zone_hit_o,
    input  wire logic              event_irq_i,
    input  wire logic              event_irq_ack_i,
    input  wire logic [15:0]       rx_data_ptr_i,
    input  wire logic [15:0]       tx_data_ptr_i,
    input  wire logic              ptr_check_i,
    input  wire logic              air_event_i,
    input  wire logic              conn_event_i,
    input  wire logic              tx_len_nonzero_i,
    input  wire logic [15:0]       rx_desc_ptr_i,
    input  wire logic [15:0]       tx_desc_ptr_i,
    input  wire logic              format_invalid_i,
    input  wire logic              hop_start_i,
    input  wire lles_pkg::lles_chmap_t hopping_channel_map_i,
    input  wire lles_pkg::lles_cnt_t   good_channel_count_i,
    input  wire logic              adv_packet_i,
    input  wire logic              adv_interval_elapsed_i,
    input  wire logic              ifs_gap_underrun_i,
    input  wire logic              allow_list_timeout_i,
    input  wire logic              prefetch_instant_i,
    input  wire logic              event_busy_i,
    input  wire logic              entry_timing_bad_i,
    input  wire logic              sched_mem_late_i,
    input  wire logic              radio_mem_late_i,
    input  wire logic              packet_mem_late_i,
    input  wire logic              decrypt_late_i,
    input  wire logic              encrypt_late_i,
    output lles_pkg::lles_err_t    link_error_type_o,
    output lles_pkg::lles_word_t   profiling_word_o,
    output lles_pkg::lles_word_t   radio_control_word0_o,
    output lles_pkg::lles_word_t   radio_control_word1_o
);
    import lles_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    lles_word_t   zone_min_q;
    lles_word_t   zone_max_q;
    lles_err_t    err_q;
    lles_err_t    err_d;
    lles_word_t   profile_q;
    lles_word_t   radio0_q;
    lles_word_t   radio1_q;
    lles_bus_st_t bus_st_q;
    logic         irq_pend_q;
    logic         adv_armed_q;
    lles_word_t   wmask;
    lles_cnt_t    ones_cnt;
    logic         req;
    logic         wr;
    logic         hit;

    assign req = wb_cyc_i && wb_stb_i && (bus_st_q == LLES_IDLE);
    assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && ce_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        case (wb_adr_i)
            `LLES_OFS_ZONE_MAX,
            `LLES_OFS_ZONE_MIN,
            `LLES_OFS_ERR_STAT,
            `LLES_OFS_PROFILE,
            `LLES_OFS_RADIO0,
            `LLES_OFS_RADIO1: hit = 1'b1;
            default:          hit = 1'b0;
        endcase
    end

    // ****************************************
    // wishbone handshake
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_q <= LLES_IDLE;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= `LLES_RST_ZERO;
        end else if (ce_i) begin
            case (bus_st_q)
                LLES_IDLE: begin
                    wb_ack_o <= req && hit;
                    wb_err_o <= req && !hit;
                    if (req) begin
                        bus_st_q <= LLES_ACK;
                    end
                    case (wb_adr_i)
                        `LLES_OFS_ZONE_MAX: wb_dat_o <= zone_max_q;
                        `LLES_OFS_ZONE_MIN: wb_dat_o <= zone_min_q;
                        `LLES_OFS_ERR_STAT: wb_dat_o <= {14'h0000, err_q};
                        `LLES_OFS_PROFILE:  wb_dat_o <= profile_q;
                        `LLES_OFS_RADIO0:   wb_dat_o <= radio0_q & ~(32'h0000_0001);
                        `LLES_OFS_RADIO1:   wb_dat_o <= radio1_q;
                        default:            wb_dat_o <= `LLES_RST_ZERO;
                    endcase
                end
                LLES_ACK: begin
                    wb_ack_o <= 1'b0;
                    wb_err_o <= 1'b0;
                    bus_st_q <= LLES_IDLE;
                end
                default: begin
                    bus_st_q <= LLES_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // zone bounds and software words
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zone_min_q <= `LLES_RST_ZERO;
            zone_max_q <= `LLES_RST_ZERO;
            profile_q  <= `LLES_RST_ZERO;
        end else if (wr) begin
            // RULE1 lower bounds word
            if (wb_adr_i == `LLES_OFS_ZONE_MIN) begin
                zone_min_q <= (zone_min_q & ~wmask) | (wb_dat_i & wmask);
            end
            // RULE2 upper bounds word
            if (wb_adr_i == `LLES_OFS_ZONE_MAX) begin
                zone_max_q <= (zone_max_q & ~wmask) | (wb_dat_i & wmask);
            end
            // RULE22 profiling word store
            if (wb_adr_i == `LLES_OFS_PROFILE) begin
                profile_q <= (profile_q & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    // radio words: bit 0 of word0 is a self-clearing strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            radio0_q <= `LLES_RST_RADIO0;
            radio1_q <= `LLES_RST_ZERO;
        end else if (ce_i) begin
            radio0_q[`LLES_RADIO0_PULSE_BIT] <= 1'b0;
            if (wr && wb_adr_i == `LLES_OFS_RADIO0) begin
                radio0_q <= (radio0_q & ~(wmask & `LLES_RADIO0_RW_MASK))
                          | (wb_dat_i & wmask & (`LLES_RADIO0_RW_MASK | 32'h0000_0001));
            end
            // RULE23 selection field storage
            if (wr && wb_adr_i == `LLES_OFS_RADIO1) begin
                radio1_q <= (radio1_q & ~(wmask & `LLES_RADIO1_RW_MASK))
                          | (wb_dat_i & wmask & `LLES_RADIO1_RW_MASK);
            end
        end
    end

    // ****************************************
    // zone hit flags
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            register_zone_hit_o     <= 1'b0;
            exchange_mem_zone_hit_o <= 1'b0;
        end else if (ce_i) begin
            // RULE3 inclusive range compare
            register_zone_hit_o     <= (reg_access_addr_i >= zone_min_q[31:16])
                                    && (reg_access_addr_i <= zone_max_q[31:16]);
            exchange_mem_zone_hit_o <= (mem_access_addr_i >= zone_min_q[15:0])
                                    && (mem_access_addr_i <= zone_max_q[15:0]);
        end
    end

    // ****************************************
    // fault detection
    // ****************************************
    always_comb begin
        ones_cnt = '0;
        for (int i = 0; i < `LLES_CHMAP_WIDTH; i++) begin
            ones_cnt = ones_cnt + lles_cnt_t'(hopping_channel_map_i[i]);
        end
    end

    // pending event interrupt and advertising spacing trackers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_pend_q  <= 1'b0;
            adv_armed_q <= 1'b0;
        end else if (ce_i) begin
            if (event_irq_i) begin
                irq_pend_q <= 1'b1;
            end else if (event_irq_ack_i) begin
                irq_pend_q <= 1'b0;
            end
            if (adv_packet_i) begin
                adv_armed_q <= 1'b1;
            end else if (adv_interval_elapsed_i) begin
                adv_armed_q <= 1'b0;
            end
        end
    end

    always_comb begin
        err_d = err_q;
        // RULE4 second irq while unacknowledged
        if (event_irq_i && irq_pend_q && !event_irq_ack_i) err_d[17] = 1'b1;
        // RULE5 null receive buffer
        if (ptr_check_i && rx_data_ptr_i == 16'h0000) err_d[16] = 1'b1;
        // RULE6 null transmit buffer
        if (ptr_check_i && tx_data_ptr_i == 16'h0000 && (air_event_i || (conn_event_i && tx_len_nonzero_i)))
            err_d[15] = 1'b1;
        // RULE7 null receive descriptor
        if (ptr_check_i && rx_desc_ptr_i == 16'h0000) err_d[14] = 1'b1;
        // RULE8 null transmit descriptor
        if (ptr_check_i && air_event_i && tx_desc_ptr_i == 16'h0000) err_d[13] = 1'b1;
        // RULE9 bad format
        if (format_invalid_i) err_d[12] = 1'b1;
        // RULE10 channel count mismatch
        if (hop_start_i && ones_cnt != good_channel_count_i) err_d[11] = 1'b1;
        // RULE11 advertising too soon
        if (adv_packet_i && adv_armed_q && !adv_interval_elapsed_i) err_d[10] = 1'b1;
        // RULE12 gap underrun
        if (ifs_gap_underrun_i) err_d[9] = 1'b1;
        // RULE13 allow list timeout
        if (allow_list_timeout_i) err_d[8] = 1'b1;
        // RULE14 prefetch overlap
        if (prefetch_instant_i && event_busy_i) begin
            err_d[7] = 1'b1;
            err_d[6] = 1'b1;
        end
        // RULE15 entry timing
        if (entry_timing_bad_i) err_d[5] = 1'b1;
        // RULE16 scheduler memory late
        if (sched_mem_late_i) err_d[4] = 1'b1;
        // RULE17 radio memory late
        if (radio_mem_late_i) err_d[3] = 1'b1;
        // RULE18 packet memory late
        if (packet_mem_late_i) err_d[2] = 1'b1;
        // RULE19 decrypt overrun
        if (decrypt_late_i) err_d[1] = 1'b1;
        // RULE20 encrypt overrun
        if (encrypt_late_i) err_d[0] = 1'b1;
    end

    // RULE21 sticky until reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_q <= '0;
        end else if (ce_i) begin
            err_q <= err_d;
        end
    end

    // ****************************************
    // mirrored outputs
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_error_type_o     <= '0;
            profiling_word_o      <= `LLES_RST_ZERO;
            radio_control_word0_o <= `LLES_RST_RADIO0;
            radio_control_word1_o <= `LLES_RST_ZERO;
        end else if (ce_i) begin
            link_error_type_o     <= err_q;
            // RULE22 copy to diagnostic port
            profiling_word_o      <= profile_q;
            radio_control_word0_o <= radio0_q;
            radio_control_word1_o <= radio1_q;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_ZONE_HIT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        ce_i && mem_access_addr_i >= zone_min_q[15:0] && mem_access_addr_i <= zone_max_q[15:0]
        |=> exchange_mem_zone_hit_o || !$past(ce_i)) else $error("zone hit missing");
    AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
        !rst_i |=> (err_q & $past(err_q)) == $past(err_q)) else $error("status bit dropped");
    AST_RXPTR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        ce_i && ptr_check_i && rx_data_ptr_i == 16'h0000 |=> err_q[16]) else $error("rx ptr fault missed");
    AST_PREFETCH: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
        ce_i && prefetch_instant_i && event_busy_i |=> err_q[7] && err_q[6]) else $error("prefetch fault missed");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        ce_i && event_irq_i && irq_pend_q && !event_irq_ack_i |=> err_q[17]) else $error("irq fault missed");
    AST_CHMAP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        ce_i && hop_start_i && ones_cnt != good_channel_count_i |=> err_q[11]) else $error("chmap fault missed");
    AST_CRYPT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
        ce_i && decrypt_late_i |=> ##1 link_error_type_o[1] || !ce_i) else $error("decrypt fault not shown");
    AST_PROFILE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
        ce_i && $past(ce_i) && !$past(rst_i) |-> profiling_word_o == $past(profile_q))
        else $error("profiling mirror wrong");

    // second event interrupt while the first is still pending
    sequence seq_irq_first;
        ce_i && event_irq_i;
    endsequence
    sequence seq_irq_second;
        ce_i && event_irq_i && !event_irq_ack_i;
    endsequence
    AST_IRQ_PAIR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        seq_irq_first ##1 (ce_i && !event_irq_ack_i) ##1 seq_irq_second |=> err_q[17])
        else $error("irq pair fault missed");
    sequence seq_adv_first;
        ce_i && adv_packet_i;
    endsequence
    sequence seq_adv_early;
        ce_i && adv_packet_i && !adv_interval_elapsed_i;
    endsequence
    AST_ADV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        seq_adv_first ##1 seq_adv_early |=> err_q[10])
        else $error("advertising underrun missed");
    AST_TXPTR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        ce_i && ptr_check_i && air_event_i && tx_data_ptr_i == 16'h0000 |=> err_q[15])
        else $error("tx ptr fault missed");
    AST_RXDESC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        ce_i && ptr_check_i && rx_desc_ptr_i == 16'h0000 |=> err_q[14])
        else $error("rx descriptor fault missed");
    AST_TXDESC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        ce_i && ptr_check_i && air_event_i && tx_desc_ptr_i == 16'h0000 |=> err_q[13])
        else $error("tx descriptor fault missed");
    AST_FORMAT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        ce_i && format_invalid_i |=> err_q[12])
        else $error("format fault missed");
    AST_GAP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        ce_i && ifs_gap_underrun_i |=> err_q[9])
        else $error("gap fault missed");
    AST_ALLOW: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        ce_i && allow_list_timeout_i |=> err_q[8])
        else $error("allow list fault missed");
    AST_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        ce_i && entry_timing_bad_i |=> err_q[5])
        else $error("entry timing fault missed");
    AST_SCHED: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
        ce_i && sched_mem_late_i |=> err_q[4])
        else $error("scheduler memory fault missed");
    AST_RADIO: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        ce_i && radio_mem_late_i |=> err_q[3])
        else $error("radio memory fault missed");
    AST_PACKET: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        ce_i && packet_mem_late_i |=> err_q[2])
        else $error("packet memory fault missed");
    AST_ENCRYPT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
        ce_i && encrypt_late_i |=> err_q[0])
        else $error("encrypt fault missed");
    AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
        !rst_i && !ce_i |=> $stable(err_q) && $stable(profiling_word_o))
        else $error("state moved while disabled");
    AST_RESET_CLEAR: assert property (@(posedge clk_i) // RULE21
        rst_i |=> err_q == '0 && link_error_type_o == '0)
        else $error("status not cleared by reset");
endmodule : lles_regs

// ---- lles_cfg.svh ----
// constants of the link error status register group
// Notes on behaviour
// RULE1: read/write word: register zone low bound high half, memory zone low bound low half.
// RULE2: companion read/write word holds both zones' high bounds, same halves.
// RULE3: zone hit flags high while access address lies within bounds, inclusive.
// RULE4: status bit 17 set on unacknowledged back-to-back concurrent event interrupts.
// RULE5: status bit 16 set when receive data buffer pointer is zero.
// RULE6: status bit 15 set on zero transmit buffer pointer in listed events.
// RULE7: status bit 14 set when receive descriptor pointer register is zero.
// RULE8: status bit 13 set on zero transmit descriptor pointer during air events.
// RULE9: status bit 12 set when control structure format is invalid.
// RULE10: status bit 11 set when channel map ones differ from good count.
// RULE11: status bit 10 set when advertising packet spacing underruns interval.
// RULE12: status bit 9 set when inter-frame gap is too short.
// RULE13: status bit 8 set when allow list parsing times out.
// RULE14: bits 7 and 6 set when first event overlaps second prefetch.
// RULE15: status bit 5 set on inconsistent timing of consecutive table entries.
// RULE16: status bit 4 set when scheduler memory accesses are late.
// RULE17: status bit 3 set when radio controller memory accesses are late.
// RULE18: status bit 2 set when packet controller memory accesses are late.
// RULE19: status bit 1 set when decryption lags the received block.
// RULE20: status bit 0 set when encryption misses the transmit block.
// RULE21: status bits stay set until core reset clears the whole word.
// RULE22: read/write profiling word copied to the diagnostic output.
// RULE23: software writes 2 into extended radio select, bits 20 to 16.
`ifndef LLES_CFG_SVH
`define LLES_CFG_SVH
`define LLES_OFS_ZONE_MAX     32'h4000_0058
`define LLES_OFS_ZONE_MIN     32'h4000_005c
`define LLES_OFS_ERR_STAT     32'h4000_0060
`define LLES_OFS_PROFILE      32'h4000_0064
`define LLES_OFS_RADIO0       32'h4000_0070
`define LLES_OFS_RADIO1       32'h4000_0074
`define LLES_RST_ZERO         32'h0000_0000
`define LLES_RST_RADIO0       32'h0000_0002
`define LLES_RADIO0_RW_MASK   32'h00fc_0062
`define LLES_RADIO0_PULSE_BIT 0
`define LLES_RADIO1_RW_MASK   32'h001f_0000
`define LLES_ERR_WIDTH        18
`define LLES_CHMAP_WIDTH      37
`endif

// ---- lles_pkg.sv ----
// types of the link error status register group
package lles_pkg;
    typedef logic [31:0] lles_word_t;
    typedef logic [17:0] lles_err_t;
    typedef logic [36:0] lles_chmap_t;
    typedef logic [5:0]  lles_cnt_t;
    typedef enum logic [1:0] {
        LLES_IDLE = 2'b00,
        LLES_ACK  = 2'b01
    } lles_bus_st_t;
endpackage : lles_pkg

// ---- lles_regs_bench.sv ----
// self-checking bench of the link error status register group
`timescale 1ns/100ps
`include "lles_cfg.svh"
module lles_regs_bench;
    import lles_pkg::*;
    // ****************************************
    // signals and behavioural model
    // ****************************************
    logic        clk_i, rst_i = 1'b1, ce_i = 1'b1;
    logic        cyc = 0, stb = 0, we = 0, ack, err, rhit, mhit;
    logic [3:0]  sel = 0;
    lles_word_t  adr = 0, wdat = 0, rdat, prof_o, r0_o, r1_o;
    logic [15:0] ra = 0, ma = 0, rxd = 16'h0a50, txd = 16'h0a50, rxs = 16'h0a50, txs = 16'h0a50;
    logic        irq = 0, iak = 0, pchk = 0, air = 0, conn = 0, txl = 0, fmt = 0, hop = 0;
    logic        adv = 0, ael = 1, pre = 0, busy = 0;
    lles_chmap_t chmap = 0;
    lles_cnt_t   gcnt = 0;
    lles_err_t   pls = 0, err_o, exp_err;
    lles_word_t  mdl [lles_word_t];
    lles_word_t  msk [lles_word_t];
    lles_word_t  adrs [7];
    logic [15:0] rb [4] = '{16'h11ff, 16'h1200, 16'h1300, 16'h1301};
    logic [15:0] mb [4] = '{16'h003f, 16'h0040, 16'h0080, 16'h0081};
    int          fail_count = 0, checks_done = 0, seed, i, k, b;

    lles_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_err_o(err), .wb_dat_o(rdat),
        .reg_access_addr_i(ra), .mem_access_addr_i(ma), .register_zone_hit_o(rhit),
        .exchange_mem_zone_hit_o(mhit), .event_irq_i(irq), .event_irq_ack_i(iak), .rx_data_ptr_i(rxd),
        .tx_data_ptr_i(txd), .ptr_check_i(pchk), .air_event_i(air), .conn_event_i(conn),
        .tx_len_nonzero_i(txl), .rx_desc_ptr_i(rxs), .tx_desc_ptr_i(txs), .format_invalid_i(fmt),
        .hop_start_i(hop), .hopping_channel_map_i(chmap), .good_channel_count_i(gcnt), .adv_packet_i(adv),
        .adv_interval_elapsed_i(ael), .ifs_gap_underrun_i(pls[9]), .allow_list_timeout_i(pls[8]),
        .prefetch_instant_i(pre), .event_busy_i(busy), .entry_timing_bad_i(pls[5]), .sched_mem_late_i(pls[4]),
        .radio_mem_late_i(pls[3]), .packet_mem_late_i(pls[2]), .decrypt_late_i(pls[1]),
        .encrypt_late_i(pls[0]), .link_error_type_o(err_o), .profiling_word_o(prof_o),
        .radio_control_word0_o(r0_o), .radio_control_word1_o(r1_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input lles_word_t got, input lles_word_t exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic mreset;
        mdl.delete();
        mdl[`LLES_OFS_ZONE_MIN] = `LLES_RST_ZERO;
        mdl[`LLES_OFS_ZONE_MAX] = `LLES_RST_ZERO;
        mdl[`LLES_OFS_PROFILE] = `LLES_RST_ZERO;
        mdl[`LLES_OFS_RADIO0] = `LLES_RST_RADIO0;
        mdl[`LLES_OFS_RADIO1] = `LLES_RST_ZERO;
        exp_err = '0;
    endtask : mreset

    function automatic logic unm(input lles_word_t a);
        return !mdl.exists(a) && a != `LLES_OFS_ERR_STAT;
    endfunction : unm

    // one classic cycle, held until ack or err is sampled high
    task automatic bus(input logic w, input lles_word_t a, input lles_word_t d, input logic [3:0] s,
                       output lles_word_t q, output logic e);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        e = err;
        chk({31'h0, ack | err}, 32'h1);
        {cyc, stb, we} <= 3'b000;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input lles_word_t a, input lles_word_t d, input logic [3:0] s);
        lles_word_t q;
        logic       e;
        bus(1'b1, a, d, s, q, e);
        if (mdl.exists(a))
            for (int j = 0; j < 4; j++)
                if (s[j])
                    mdl[a][8*j +: 8] = d[8*j +: 8] & msk[a][8*j +: 8];
        chk({31'h0, e}, {31'h0, unm(a)});
    endtask : wr

    task automatic rd(input lles_word_t a);
        lles_word_t q;
        logic       e;
        bus(1'b0, a, 32'h0, 4'hf, q, e);
        chk(q, (a == `LLES_OFS_ERR_STAT) ? {14'h0, exp_err} : (mdl.exists(a) ? mdl[a] : 32'h0));
        chk({31'h0, e}, {31'h0, unm(a)});
    endtask : rd

    task automatic idle;
        {irq, iak, pchk, air, conn, txl, fmt, hop, adv, pre, busy} <= '0;
        pls <= '0;
        {rxd, txd, rxs, txs} <= {4{16'h0a50}};
        ael <= 1'b1;
    endtask : idle

    // drives the cause of one status bit for a cycle; bits 17 and 10 take two pulses over three and two cycles
    task automatic fire(input int b);
        case (b)
            17: begin
                irq <= 1'b1;
                @(posedge clk_i);
                irq <= 1'b0;
                @(posedge clk_i);
                irq <= 1'b1;
            end
            16: {rxd, pchk} <= 17'h1;
            15: {txd, air, pchk} <= 18'h3;
            14: {rxs, pchk} <= 17'h1;
            13: {txs, air, pchk} <= 18'h3;
            12: fmt <= 1'b1;
            11: {chmap, gcnt, hop} <= {37'h1, 6'd2, 1'b1};
            10: begin
                adv <= 1'b1;
                @(posedge clk_i);
                {adv, ael} <= 2'b10;
            end
            7, 6: {pre, busy} <= 2'b11;
            default: pls[b] <= 1'b1;
        endcase
        @(posedge clk_i);
        idle();
        exp_err[b] = 1'b1;
        if (b == 7 || b == 6)
            exp_err[7:6] = 2'b11;
        @(posedge clk_i);
    endtask : fire

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 26391;
        adrs = '{`LLES_OFS_ZONE_MIN, `LLES_OFS_ZONE_MAX, `LLES_OFS_ERR_STAT, `LLES_OFS_PROFILE,
                 `LLES_OFS_RADIO0, `LLES_OFS_RADIO1, 32'h4000_0068};
        msk[`LLES_OFS_ZONE_MIN] = 32'hffff_ffff;
        msk[`LLES_OFS_ZONE_MAX] = 32'hffff_ffff;
        msk[`LLES_OFS_PROFILE] = 32'hffff_ffff;
        msk[`LLES_OFS_RADIO0] = `LLES_RADIO0_RW_MASK;
        msk[`LLES_OFS_RADIO1] = `LLES_RADIO1_RW_MASK;
        mreset();
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 7; i++)
            rd(adrs[i]);
        for (k = 0; k < 4; k++)
            for (i = 0; i < 7; i++) begin
                wr(adrs[i], $random(seed), 4'($random(seed)));
                rd(adrs[i]);
                chk(prof_o, mdl[`LLES_OFS_PROFILE]);
                chk(r0_o, mdl[`LLES_OFS_RADIO0]);
                chk(r1_o, mdl[`LLES_OFS_RADIO1]);
            end
        wr(`LLES_OFS_RADIO1, 32'h0002_0000, 4'hf);
        rd(`LLES_OFS_RADIO1);
        wr(`LLES_OFS_ZONE_MIN, 32'h1200_0040, 4'hf);
        wr(`LLES_OFS_ZONE_MAX, 32'h1300_0080, 4'hf);
        for (k = 0; k < 24; k++) begin
            ra <= (k < 4) ? rb[k] : 16'h1180 + {7'h0, 9'($random(seed))};
            ma <= (k < 4) ? mb[k] : 16'h0020 + {9'h0, 7'($random(seed))};
            repeat (2) @(posedge clk_i);
            chk({31'h0, rhit}, {31'h0, ra >= 16'h1200 && ra <= 16'h1300});
            chk({31'h0, mhit}, {31'h0, ma >= 16'h0040 && ma <= 16'h0080});
        end
        // near misses: acked interrupt, zero-length connection, matching map, spaced packets, idle prefetch
        {irq, adv} <= 2'b11;
        @(posedge clk_i);
        idle();
        iak <= 1'b1;
        @(posedge clk_i);
        idle();
        {irq, adv, pchk, conn, txd, chmap, gcnt, hop, pre} <= {4'hf, 16'h0, 37'h3, 6'd2, 2'b11};
        @(posedge clk_i);
        idle();
        iak <= 1'b1;
        @(posedge clk_i);
        idle();
        @(posedge clk_i);
        // clock enable low: a format fault must not be recorded
        ce_i <= 1'b0;
        fmt  <= 1'b1;
        repeat (3) @(posedge clk_i);
        {ce_i, fmt} <= 2'b10;
        @(posedge clk_i);
        chk({14'h0, err_o}, 32'h0);
        rd(`LLES_OFS_ERR_STAT);
        for (b = 17; b >= 0; b--) begin
            fire(b);
            rd(`LLES_OFS_ERR_STAT);
            chk({14'h0, err_o}, {14'h0, exp_err});
        end
        wr(`LLES_OFS_ERR_STAT, 32'h0, 4'hf);
        rd(`LLES_OFS_ERR_STAT);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        mreset();
        @(posedge clk_i);
        for (i = 0; i < 7; i++)
            rd(adrs[i]);
        chk({14'h0, err_o}, {14'h0, exp_err});
        tally_and_finish();
    end
endmodule : lles_regs_bench
